// >>> pkg/ffseq_pkg.sv
// Package for the fixed-frequency sequencer: register map, codes, timing.
// Assumes a 200 MHz pclk and an APB master with 32-bit data.
// ****************************************************************
// Register map
// ****************************************************************
package ffseq_pkg;
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_DIR = 8'h04;
  localparam logic [7:0] OFF_START_SEL = 8'h08;
  localparam logic [7:0] OFF_PAUSE_SEL = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_TIME0 = 8'h20;
  localparam logic [7:0] OFF_TIME7 = 8'h3C;
  localparam int MODE_W = 3;
  localparam int DIR_W = 8;
  localparam int TIME_W = 10;
  localparam int SEL_W = 3;
  localparam int STEPS = 8;
  localparam int DI_W = 6;
  localparam logic [MODE_W-1:0] RST_MODE = 3'h0;
  localparam logic [DIR_W-1:0] RST_DIR = 8'h00;
  localparam logic [TIME_W-1:0] RST_TIME = 10'h000;
  localparam logic [SEL_W-1:0] RST_SEL = 3'h0;
  localparam logic [TIME_W-1:0] TIME_MAX = 10'h3E8;
  // ****************************************************************
  // Mode codes
  // ****************************************************************
  localparam logic [MODE_W-1:0] MODE_OFF = 3'h0;
  localparam logic [MODE_W-1:0] MODE_ONCE = 3'h1;
  localparam logic [MODE_W-1:0] MODE_CONT = 3'h2;
  localparam logic [MODE_W-1:0] MODE_STEP_ONCE = 3'h3;
  localparam logic [MODE_W-1:0] MODE_STEP_CONT = 3'h4;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 200000000;
  localparam int TICK_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_S;
  localparam int TICK_W = 28;
  // ****************************************************************
  // Sequencer states, Gray along idle-run-gap-done
  // ****************************************************************
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_GAP = 2'h3,
    ST_DONE = 2'h2
  } ffseq_state_e;
endpackage

// >>> hw/ffseq_di_select.sv
// Picks one of the six digital inputs by a 3-bit assignment, 0 = none.
// Assumes inputs synchronous to pclk; output is registered.
`timescale 1ns/10ps
`default_nettype none
module ffseq_di_select
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] digital_inputs,
  input wire logic [2:0] sel,
  output logic level_ff
);
  logic nxt_level;

  always_comb
  begin
    nxt_level = 1'b0;
    if ((sel != 3'h0) && (sel <= 3'h6))
    begin
      nxt_level = digital_inputs[sel - 3'h1];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_ff <= 1'b0;
    end
    else
    begin
      level_ff <= nxt_level;
    end
  end
endmodule
`default_nettype wire

// >>> hw/ffseq_sec_tick.sv
// One-second tick generator; restart realigns the second to a step start.
// Assumes pclk at the rate the package gives.
`timescale 1ns/10ps
`default_nettype none
module ffseq_sec_tick
#(
  parameter int TICK_CYCLES = ffseq_pkg::TICK_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  input wire logic hold,
  output logic tick_ff
);
  logic [ffseq_pkg::TICK_W-1:0] cnt_ff;
  logic [ffseq_pkg::TICK_W-1:0] nxt_cnt;
  logic nxt_tick;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (restart)
    begin
      nxt_cnt = '0;
    end
    else if (!hold)
    begin
      if (cnt_ff == ffseq_pkg::TICK_W'(TICK_CYCLES - 1))
      begin
        nxt_cnt = '0;
        nxt_tick = 1'b1;
      end
      else
      begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end
endmodule
`default_nettype wire

// >>> hw/ffseq_top.sv
// Fixed-frequency sequencer: APB registers, start/pause input select,
// step sequencing over eight stored setpoints with per-step direction.
// Assumes the drive ramp generator follows step_index_ff/reverse_ff while
// seq_active_ff is high, and reports drive_at_zero when output is zero.
// Operation
// - Mode 0 off, 1 once, 2 continuous, 3 once stepped, 4 continuous stepped.
// - Start command comes from the digital input chosen by start assignment.
// - Pause comes from the digital input chosen by pause assignment.
// - Direction program is an 8-bit value, 0 to 255.
// - Bit n gives step n direction: 0 forward, 1 reverse.
// - A step with zero run time is skipped.
// - Eight run times, 0 to 1000 seconds, reset to zero.
// - Run-once outputs steps ascending, each for its time and direction.
// - Sequence start command overrides every other drive start source.
// - Running sequence setpoint overrides every other setpoint source.
// - Mode and direction program reset to zero.
// - Sequence cycles over eight setpoints, each with direction and time.
// - Start removal ends the sequence at once; next start begins at the first step with nonzero time.
// - Pause holds the current step; release resumes it.
// - Stepped modes bring output to zero between steps.
// - Start already high at power-up starts without an edge.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ffseq_top
#(
  parameter int TICK_CYCLES = ffseq_pkg::TICK_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  input wire logic [5:0] digital_inputs,
  input wire logic drive_at_zero,
  output logic [2:0] step_index_ff,
  output logic reverse_ff,
  output logic seq_active_ff,
  output logic start_cmd_ff,
  output logic stop_req_ff,
  output logic paused_ff,
  output logic step_end_ff,
  output logic cycle_end_ff
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Next step at or after first with nonzero time; bit 3 flags found
  function automatic logic [3:0] find_active(input logic [2:0] first,
                                             input logic [7:0] mask);
    logic [3:0] res;
    res = 4'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if ((3'(i) >= first) && mask[i])
        res = {1'b1, 3'(i)};
    end
    return res;
  endfunction

  // Writes above the range saturate rather than wrap
  function automatic logic [9:0] clamp_time(input logic [31:0] v);
    logic [9:0] r;
    r = ffseq_pkg::TIME_MAX;
    if (v[31:10] == 22'h0 && v[9:0] <= ffseq_pkg::TIME_MAX)
      r = v[9:0];
    return r;
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [2:0] mode_ff, nxt_mode;
  logic [7:0] dir_ff, nxt_dir;
  logic [2:0] start_sel_ff, nxt_start_sel;
  logic [2:0] pause_sel_ff, nxt_pause_sel;
  logic [9:0] time_ff [8];
  logic [9:0] nxt_time [8];
  logic [31:0] nxt_prdata;
  logic nxt_pready, nxt_pslverr;
  logic [7:0] active_mask;
  logic [9:0] remain_ff, nxt_remain;
  ffseq_pkg::ffseq_state_e state_ff, nxt_state;
  logic start_lvl, pause_lvl, tick, tick_restart;
  logic [2:0] nxt_step;
  logic nxt_active, nxt_start_cmd, nxt_stop, nxt_step_end, nxt_cycle_end;
  logic [3:0] nxt_found, first_found;
  logic stepped, continuous, acc;
  logic [2:0] ridx;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
      active_mask[i] = (time_ff[i] != ffseq_pkg::RST_TIME);
  end

  assign acc = psel && penable;
  assign ridx = paddr[4:2];

  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_dir = dir_ff;
    nxt_start_sel = start_sel_ff;
    nxt_pause_sel = pause_sel_ff;
    nxt_time = time_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    nxt_pready = acc && !pready_ff;
    if (acc && pready_ff && pwrite)
    begin
      if (paddr == ffseq_pkg::OFF_MODE)
        nxt_mode = pwdata[2:0];
      else if (paddr == ffseq_pkg::OFF_DIR)
        nxt_dir = pwdata[7:0];
      else if (paddr == ffseq_pkg::OFF_START_SEL)
        nxt_start_sel = pwdata[2:0];
      else if (paddr == ffseq_pkg::OFF_PAUSE_SEL)
        nxt_pause_sel = pwdata[2:0];
      else if (paddr >= ffseq_pkg::OFF_TIME0 && paddr <= ffseq_pkg::OFF_TIME7 && paddr[1:0] == 2'h0)
        nxt_time[ridx] = clamp_time(pwdata);
    end
    // Error only with ready, so it drops with ready
    if (acc && !pready_ff)
    begin
      nxt_prdata = 32'h0;
      if (paddr == ffseq_pkg::OFF_MODE)
        nxt_prdata = {29'h0, mode_ff};
      else if (paddr == ffseq_pkg::OFF_DIR)
        nxt_prdata = {24'h0, dir_ff};
      else if (paddr == ffseq_pkg::OFF_START_SEL)
        nxt_prdata = {29'h0, start_sel_ff};
      else if (paddr == ffseq_pkg::OFF_PAUSE_SEL)
        nxt_prdata = {29'h0, pause_sel_ff};
      else if (paddr == ffseq_pkg::OFF_STATUS)
        nxt_prdata = {10'h0, remain_ff, 4'h0, paused_ff, step_index_ff, 2'h0, state_ff};
      else if (paddr >= ffseq_pkg::OFF_TIME0 && paddr <= ffseq_pkg::OFF_TIME7 && paddr[1:0] == 2'h0)
        nxt_prdata = {22'h0, time_ff[ridx]};
      else
        nxt_pslverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_ff <= ffseq_pkg::RST_MODE;
      dir_ff <= ffseq_pkg::RST_DIR;
      start_sel_ff <= ffseq_pkg::RST_SEL;
      pause_sel_ff <= ffseq_pkg::RST_SEL;
      for (int i = 0; i < 8; i++)
      begin
        time_ff[i] <= ffseq_pkg::RST_TIME;
      end
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      dir_ff <= nxt_dir;
      start_sel_ff <= nxt_start_sel;
      pause_sel_ff <= nxt_pause_sel;
      time_ff <= nxt_time;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ****************************************************************
  // Inputs and second tick
  // ****************************************************************
  ffseq_di_select u_start
  (
    .pclk(pclk),
    .presetn(presetn),
    .digital_inputs(digital_inputs),
    .sel(start_sel_ff),
    .level_ff(start_lvl)
  );

  ffseq_di_select u_pause
  (
    .pclk(pclk),
    .presetn(presetn),
    .digital_inputs(digital_inputs),
    .sel(pause_sel_ff),
    .level_ff(pause_lvl)
  );

  // Tick frozen during pause so a paused second is not lost
  ffseq_sec_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick
  (
    .pclk(pclk),
    .presetn(presetn),
    .restart(tick_restart),
    .hold(pause_lvl),
    .tick_ff(tick)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  assign stepped = (mode_ff == ffseq_pkg::MODE_STEP_ONCE) || (mode_ff == ffseq_pkg::MODE_STEP_CONT);
  assign continuous = (mode_ff == ffseq_pkg::MODE_CONT) || (mode_ff == ffseq_pkg::MODE_STEP_CONT);
  assign first_found = find_active(3'h0, active_mask);
  assign nxt_found = (step_index_ff == 3'h7) ? 4'h0 : find_active(step_index_ff + 3'h1, active_mask);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_step = step_index_ff;
    nxt_remain = remain_ff;
    nxt_stop = 1'b0;
    nxt_step_end = 1'b0;
    nxt_cycle_end = 1'b0;
    tick_restart = 1'b0;
    // Level start, so a start held over reset needs no edge
    if (!start_lvl || mode_ff == ffseq_pkg::MODE_OFF || mode_ff > ffseq_pkg::MODE_STEP_CONT)
    begin
      nxt_state = ffseq_pkg::ST_IDLE;
      nxt_step = 3'h0;
      nxt_remain = '0;
    end
    else
    begin
      case (state_ff)
        ffseq_pkg::ST_IDLE:
        begin
          if (first_found[3])
          begin
            nxt_state = ffseq_pkg::ST_RUN;
            nxt_step = first_found[2:0];
            nxt_remain = time_ff[first_found[2:0]];
            tick_restart = 1'b1;
          end
        end
        ffseq_pkg::ST_RUN:
        begin
          if (!pause_lvl && tick)
          begin
            if (remain_ff <= 10'h001)
            begin
              nxt_step_end = 1'b1;
              nxt_remain = '0;
              if (!nxt_found[3] && !continuous)
              begin
                nxt_state = ffseq_pkg::ST_DONE;
                nxt_cycle_end = 1'b1;
              end
              else if (stepped)
              begin
                nxt_state = ffseq_pkg::ST_GAP;
                nxt_cycle_end = !nxt_found[3];
              end
              else if (nxt_found[3])
              begin
                nxt_step = nxt_found[2:0];
                nxt_remain = time_ff[nxt_found[2:0]];
              end
              else
              begin
                nxt_step = first_found[2:0];
                nxt_remain = time_ff[first_found[2:0]];
                nxt_cycle_end = 1'b1;
              end
            end
            else
              nxt_remain = remain_ff - 10'h001;
          end
        end
        ffseq_pkg::ST_GAP:
        begin
          nxt_stop = 1'b1;
          if (drive_at_zero && !pause_lvl)
          begin
            if (nxt_found[3] || first_found[3])
            begin
              nxt_state = ffseq_pkg::ST_RUN;
              nxt_step = nxt_found[3] ? nxt_found[2:0] : first_found[2:0];
              nxt_remain = time_ff[nxt_step];
              tick_restart = 1'b1;
              nxt_stop = 1'b0;
            end
            else
              nxt_state = ffseq_pkg::ST_DONE;
          end
        end
        default:
          nxt_stop = 1'b1; // Once done, wait here until start drops
      endcase
    end
    nxt_active = (nxt_state == ffseq_pkg::ST_RUN) || (nxt_state == ffseq_pkg::ST_GAP);
    nxt_start_cmd = nxt_active;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= ffseq_pkg::ST_IDLE;
      step_index_ff <= 3'h0;
      remain_ff <= '0;
      reverse_ff <= 1'b0;
      seq_active_ff <= 1'b0;
      start_cmd_ff <= 1'b0;
      stop_req_ff <= 1'b0;
      paused_ff <= 1'b0;
      step_end_ff <= 1'b0;
      cycle_end_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      step_index_ff <= nxt_step;
      remain_ff <= nxt_remain;
      reverse_ff <= nxt_active && dir_ff[nxt_step];
      seq_active_ff <= nxt_active;
      start_cmd_ff <= nxt_start_cmd;
      stop_req_ff <= nxt_stop;
      paused_ff <= nxt_active && pause_lvl;
      step_end_ff <= nxt_step_end;
      cycle_end_ff <= nxt_cycle_end;
    end
  end
endmodule
`default_nettype wire

// >>> verification/ffseq_chk.sv
// Checker: bus handshake and sequencer output relations.
// Assumes binding to ffseq_top; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module ffseq_chk
#(
  parameter int TICK_CYCLES = 20
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_ff,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  input wire logic [5:0] digital_inputs,
  input wire logic drive_at_zero,
  input wire logic [2:0] step_index_ff,
  input wire logic reverse_ff,
  input wire logic seq_active_ff,
  input wire logic start_cmd_ff,
  input wire logic stop_req_ff,
  input wire logic paused_ff,
  input wire logic step_end_ff,
  input wire logic cycle_end_ff
);
  // ****
  // Shadow of the direction program, taken at the bus commit edge
  // ****
  logic [7:0] dir_ff;
  logic [7:0] nxt_dir;
  always_comb
  begin
    nxt_dir = dir_ff;
    if (psel && penable && pready_ff && pwrite && paddr == ffseq_pkg::OFF_DIR)
    begin
      nxt_dir = pwdata[7:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_ff <= 8'h00;
    end
    else
    begin
      dir_ff <= nxt_dir;
    end
  end
  // Cycles since the last step end, saturating at one tick period
  int since_ff;
  int nxt_since;
  always_comb
  begin
    nxt_since = since_ff;
    if (step_end_ff)
      nxt_since = 1;
    else if (since_ff < TICK_CYCLES)
      nxt_since = since_ff + 1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      since_ff <= TICK_CYCLES;
    else
      since_ff <= nxt_since;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access1;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_answer;
    !pready_ff ##1 pready_ff;
  endsequence
  a_ready_second: assert property (s_access1 |-> s_answer) else $error("ready not in second access cycle");
  a_ready_pulse: assert property (pready_ff |=> !pready_ff) else $error("ready longer than one cycle");
  a_error_ready: assert property (pslverr_ff |-> pready_ff) else $error("error without ready");
  a_start_follows: assert property (start_cmd_ff == seq_active_ff) else $error("start command not tied to run");
  a_pause_active: assert property (paused_ff |-> seq_active_ff) else $error("paused while idle");
  a_pause_holds: assert property (paused_ff ##1 paused_ff |-> $stable(step_index_ff)) else $error("step moved in pause");
  a_dir_follows: assert property (seq_active_ff && !stop_req_ff |-> reverse_ff == dir_ff[step_index_ff]) else $error("bad direction");
  a_end_pairs: assert property (cycle_end_ff |-> step_end_ff) else $error("cycle end without step end");
  a_step_spacing: assert property (step_end_ff |=> !step_end_ff [*8]) else $error("step ends too close");
  a_tick_spacing: assert property (step_end_ff |-> since_ff >= TICK_CYCLES) else $error("step under one tick");
endmodule
bind ffseq_top ffseq_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
  .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .digital_inputs(digital_inputs), .drive_at_zero(drive_at_zero),
  .step_index_ff(step_index_ff), .reverse_ff(reverse_ff), .seq_active_ff(seq_active_ff),
  .start_cmd_ff(start_cmd_ff), .stop_req_ff(stop_req_ff), .paused_ff(paused_ff), .step_end_ff(step_end_ff),
  .cycle_end_ff(cycle_end_ff));
`default_nettype wire

// >>> verification/ffseq_drive_model.sv
// Drive model: output leaves zero on a running step, ramps to zero on stop.
// Assumes sequencer outputs of ffseq_top; slow selects a long ramp.
`timescale 1ns/10ps
`default_nettype none
module ffseq_drive_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic stop_req,
  input wire logic slow,
  output logic at_zero_ff
);
  int cnt_ff;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= 0;
      at_zero_ff <= 1'h1;
    end
    else if (run && !stop_req)
    begin
      cnt_ff <= slow ? 12 : 2;
      at_zero_ff <= 1'h0;
    end
    else if (cnt_ff > 0)
    begin
      cnt_ff <= cnt_ff - 1;
    end
    else
    begin
      at_zero_ff <= 1'h1;
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Testbench: register checks, then all modes against a step-order model.
// Assumes ffseq_top with a short tick and the drive model as partner.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int TC = 20;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [5:0] digital_inputs = 6'h00;
  logic slow = 1'h0;
  logic [31:0] prdata_ff;
  logic [2:0] step_index_ff;
  logic pready_ff, pslverr_ff, drive_at_zero, reverse_ff, seq_active_ff, start_cmd_ff;
  logic stop_req_ff, paused_ff, step_end_ff, cycle_end_ff, er;
  logic [31:0] rd;
  logic [7:0] lf = 8'h32;
  logic [7:0] dir;
  int n_fail = 0;
  int num_checks = 0;
  int tm[8];
  int na;
  always #2.5 pclk = ~pclk;
  ffseq_top #(.TICK_CYCLES(TC)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff), .digital_inputs(digital_inputs), .drive_at_zero(drive_at_zero),
    .step_index_ff(step_index_ff), .reverse_ff(reverse_ff), .seq_active_ff(seq_active_ff),
    .start_cmd_ff(start_cmd_ff), .stop_req_ff(stop_req_ff), .paused_ff(paused_ff),
    .step_end_ff(step_end_ff), .cycle_end_ff(cycle_end_ff));
  ffseq_drive_model drv_u (.pclk(pclk), .presetn(presetn), .run(seq_active_ff), .stop_req(stop_req_ff),
    .slow(slow), .at_zero_ff(drive_at_zero));
  // ****
  // Helpers
  // ****
  function automatic logic [7:0] nxt_lf(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic int nxt_step(input int s);
    for (int k = 1; k <= 8; k++)
      if (tm[(s + k) % 8] > 0)
        return (s + k) % 8;
    return -1;
  endfunction
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task tmo(input int c, input int lim);
    if (c >= lim)
    begin
      n_fail++;
      $display("MISMATCH wait exp done seen hang");
      stop_test();
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    c = 0;
    do
    begin
      @(posedge pclk);
      c++;
    end
    while (pready_ff !== 1'h1 && c < 50);
    tmo(c, 50);
    rd = prdata_ff;
    er = pslverr_ff;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task run_seq(input int mode, input int n, input int pi);
    int s, c, ex;
    s = -1;
    for (int i = 0; i < n; i++)
    begin
      s = nxt_step(s);
      c = 0;
      while (!(seq_active_ff === 1'h1 && stop_req_ff === 1'h0) && c < 200)
      begin
        @(posedge pclk);
        c++;
      end
      tmo(c, 200);
      @(posedge pclk);
      chk("step", step_index_ff, s);
      chk("reverse", reverse_ff, dir[s]);
      chk("start_cmd", start_cmd_ff, 1'h1);
      chk("active", seq_active_ff, 1'h1);
      c = 1;
      while (step_end_ff !== 1'h1 && c < 30000)
      begin
        @(posedge pclk);
        c++;
        if (i == pi && c == 4)
          digital_inputs[1] <= 1'h1;
        if (i == pi && c == 34)
          digital_inputs[1] <= 1'h0;
        if (i == pi && c == 20)
          chk("paused", paused_ff, 1'h1);
      end
      tmo(c, 30000);
      ex = tm[s] * TC + ((i == pi) ? 30 : 0);
      chk("step_time", c > ex - 4 && c < ex + 4, 1'h1);
      chk("cycle_end", cycle_end_ff, nxt_step(s) <= s);
      @(posedge pclk);
      if (mode >= 3)
      begin
        @(posedge pclk);
        chk("gap_stop", stop_req_ff, 1'h1);
        if (nxt_step(s) > s)
          chk("gap_step", step_index_ff, s);
      end
    end
    if (mode % 2 == 1)
    begin
      repeat (3) @(posedge pclk);
      chk("done_idle", seq_active_ff, 1'h0);
      chk("done_stop", stop_req_ff, 1'h1);
    end
  endtask
  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int k = 0; k < 10; k++)
    begin
      apb(1'h0, (k < 2) ? 8'(k * 4) : 8'(8'h20 + (k - 2) * 4), 32'h0);
      chk("reset_value", rd, 32'h0);
    end
    apb(1'h0, 8'h44, 32'h0);
    chk("unmapped_err", er, 1'h1);
    dir = lf;
    apb(1'h1, ffseq_pkg::OFF_DIR, {24'hA5A5A5, dir});
    apb(1'h0, ffseq_pkg::OFF_DIR, 32'h0);
    chk("direction", rd, {24'h0, dir});
    apb(1'h1, ffseq_pkg::OFF_TIME7, 32'h3FF);
    apb(1'h0, ffseq_pkg::OFF_TIME7, 32'h0);
    chk("time_max", rd, 32'h3E8);
    na = 0;
    for (int k = 0; k < 8; k++)
    begin
      lf = nxt_lf(lf);
      tm[k] = (k == 0) ? 1 + lf % 3 : lf % 4;
      na += (tm[k] > 0);
      apb(1'h1, 8'(8'h20 + k * 4), 32'(tm[k]));
    end
    apb(1'h1, ffseq_pkg::OFF_START_SEL, 32'h1);
    apb(1'h1, ffseq_pkg::OFF_PAUSE_SEL, 32'h2);
    $display("register test done");
    for (int m = 0; m < 6; m++)
    begin
      slow <= (m >= 3);
      apb(1'h1, ffseq_pkg::OFF_MODE, 32'h0);
      digital_inputs[0] <= 1'h1;
      apb(1'h1, ffseq_pkg::OFF_MODE, 32'(m));
      if (m == 0 || m == 5)
      begin
        repeat (10) @(posedge pclk);
        chk("refused", seq_active_ff, 1'h0);
      end
      else
        run_seq(m, (m % 2 == 1) ? na : na + 2, (m == 2) ? 1 : -1);
      digital_inputs[0] <= 1'h0;
      repeat (4) @(posedge pclk);
      chk("start_drop", seq_active_ff, 1'h0);
      chk("start_cmd_drop", start_cmd_ff, 1'h0);
      $display("mode %0d test done", m);
    end
    stop_test();
  end
endmodule
`default_nettype wire
